// *** sbd_pkg.sv ***
// Constants shared by the subtract, borrow and decrement-skip datapath.
//
// Notes on behaviour
// RULE1: Accumulator gets accumulator minus memory minus borrow.
// RULE2: Memory gets same difference; accumulator keeps value.
// RULE3: Carry cleared on borrow, set otherwise.
// RULE4: Subtracts update overflow, zero, aux carry, carry.
// RULE5: Decrement memory byte and store it back.
// RULE6: Zero result suppresses the next instruction.
// RULE7: Taken skip costs two cycles via dummy.
// RULE8: Nonzero result continues without any skip.
package sbd_pkg;

    localparam int DATA_W = 8;

    // Operation codes presented with the execute strobe.
    localparam logic [1:0] OP_SUB_BORROW_TO_ACC  = 2'h0;
    localparam logic [1:0] OP_SUB_BORROW_TO_MEM  = 2'h1;
    localparam logic [1:0] OP_DECREMENT_SKIP_ZERO = 2'h2;

    // Register port map, one byte per index.
    localparam logic [1:0] REG_ACCUMULATOR = 2'h0;
    localparam logic [1:0] REG_STATUS      = 2'h1;

    // Status byte field positions.
    localparam int FLAG_CARRY     = 0;
    localparam int FLAG_AUX_CARRY = 1;
    localparam int FLAG_ZERO      = 2;
    localparam int FLAG_OVERFLOW  = 3;

    // Values after reset.
    localparam logic [7:0] RST_ACCUMULATOR = 8'h00;
    localparam logic       RST_FLAG        = 1'b0;

    // Cycles a taken skip occupies, the dummy cycle included.
    localparam int SKIP_CYCLES = 2;

    // One-hot sequencer states.
    typedef enum logic [1:0] {
        SBD_RUN   = 2'b01,
        SBD_DUMMY = 2'b10
    } sbd_state_t;

endpackage

// *** sbd_sub_unit.sv ***
// Combinational subtract-with-borrow and its four status results.
`timescale 1ns/10ps
module sbd_sub_unit #(
    parameter int W = sbd_pkg::DATA_W
) (
    input  wire logic [W-1:0] minuend_i,
    input  wire logic [W-1:0] subtrahend_i,
    input  wire logic         carry_i,
    output logic      [W-1:0] diff_o,
    output logic              carry_o,
    output logic              aux_carry_o,
    output logic              overflow_o,
    output logic              zero_o
);
    logic [W:0] full_sum;
    logic [4:0] low_sum;

    // Subtraction as addition of the inverse: a + ~b + C equals a - b - !C,
    // so the adder carry out is directly "no borrow".
    always_comb begin
        full_sum    = {1'b0, minuend_i} + {1'b0, ~subtrahend_i} +
                      {{W{1'b0}}, carry_i};
        low_sum     = {1'b0, minuend_i[3:0]} + {1'b0, ~subtrahend_i[3:0]} +
                      {4'h0, carry_i};
        diff_o      = full_sum[W-1:0];                       // RULE1
        carry_o     = full_sum[W];                           // RULE3
        aux_carry_o = low_sum[4];                            // RULE4
        overflow_o  = (minuend_i[W-1] != subtrahend_i[W-1]) &&
                      (full_sum[W-1] != minuend_i[W-1]);     // RULE4
        zero_o      = (full_sum[W-1:0] == '0);               // RULE4
    end
endmodule

// *** sbd_core.sv ***
// Execution of the two subtract-with-borrow forms and decrement-skip.
`timescale 1ns/10ps
module sbd_core (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       exec_i,
    input  wire logic [1:0] op_i,
    input  wire logic [7:0] mem_data_i,
    input  wire logic [1:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    output logic      [7:0] mem_wdata_o,
    output logic            mem_wr_o,
    output logic            skip_o,
    output logic            busy_o,
    output logic            done_o
);
    logic [7:0]         accumulator;
    logic               carry_flag;
    logic               aux_carry_flag;
    logic               zero_flag;
    logic               overflow_flag;
    logic [7:0]         next_accumulator;
    logic               next_carry_flag;
    logic               next_aux_carry_flag;
    logic               next_zero_flag;
    logic               next_overflow_flag;
    logic [7:0]         next_mem_wdata;
    logic               next_mem_wr;
    logic               next_skip;
    logic               next_busy;
    logic               next_done;
    logic [7:0]         next_rdata;
    sbd_pkg::sbd_state_t state;
    sbd_pkg::sbd_state_t next_state;
    logic [7:0]         diff;
    logic               sub_carry;
    logic               sub_aux;
    logic               sub_ovf;
    logic               sub_zero;
    logic [7:0]         dec_value;
    logic               take;

    // Status byte as software sees it; upper bits read as zero.
    function automatic logic [7:0] status_byte(input logic c, input logic a,
                                               input logic z, input logic o);
        logic [7:0] s;
        s = 8'h00;
        s[sbd_pkg::FLAG_CARRY]     = c;
        s[sbd_pkg::FLAG_AUX_CARRY] = a;
        s[sbd_pkg::FLAG_ZERO]      = z;
        s[sbd_pkg::FLAG_OVERFLOW]  = o;
        return s;
    endfunction

    sbd_sub_unit #(
        .W (sbd_pkg::DATA_W)
    ) u_sub (
        .minuend_i    (accumulator),
        .subtrahend_i (mem_data_i),
        .carry_i      (carry_flag),
        .diff_o       (diff),
        .carry_o      (sub_carry),
        .aux_carry_o  (sub_aux),
        .overflow_o   (sub_ovf),
        .zero_o       (sub_zero)
    );

    assign dec_value = mem_data_i - 8'h01;                    // RULE5
    // The dummy cycle refuses a new instruction, just as the fetch of the
    // skipped instruction is discarded in the core pipeline.
    assign take = exec_i && (state == sbd_pkg::SBD_RUN);

    // Next state of the architectural registers and the result strobes.
    always_comb begin
        next_accumulator    = accumulator;
        next_carry_flag     = carry_flag;
        next_aux_carry_flag = aux_carry_flag;
        next_zero_flag      = zero_flag;
        next_overflow_flag  = overflow_flag;
        next_mem_wdata      = mem_wdata_o;
        next_mem_wr         = 1'b0;
        next_skip           = 1'b0;
        next_busy           = 1'b0;
        next_done           = 1'b0;
        next_state          = sbd_pkg::SBD_RUN;
        unique case (state)
            sbd_pkg::SBD_RUN: begin
                if (take) begin
                    next_done = 1'b1;
                    if (op_i == sbd_pkg::OP_SUB_BORROW_TO_ACC ||
                        op_i == sbd_pkg::OP_SUB_BORROW_TO_MEM) begin
                        next_carry_flag     = sub_carry;      // RULE3
                        next_aux_carry_flag = sub_aux;        // RULE4
                        next_zero_flag      = sub_zero;       // RULE4
                        next_overflow_flag  = sub_ovf;        // RULE4
                    end
                    if (op_i == sbd_pkg::OP_SUB_BORROW_TO_ACC) begin
                        next_accumulator = diff;              // RULE1
                    end else if (op_i == sbd_pkg::OP_SUB_BORROW_TO_MEM) begin
                        next_mem_wdata = diff;                // RULE2
                        next_mem_wr    = 1'b1;                // RULE2
                    end else if (op_i == sbd_pkg::OP_DECREMENT_SKIP_ZERO) begin
                        next_mem_wdata = dec_value;           // RULE5
                        next_mem_wr    = 1'b1;                // RULE5
                        if (dec_value == 8'h00) begin  // RULE6 RULE8
                            next_skip  = 1'b1;                // RULE6
                            next_busy  = 1'b1;                // RULE7
                            next_done  = 1'b0;                // RULE7
                            next_state = sbd_pkg::SBD_DUMMY;  // RULE7
                        end
                    end
                end else if (reg_wr_i) begin
                    // A write in the same cycle as an accepted instruction
                    // is dropped so the flags always reflect the last op.
                    if (reg_addr_i == sbd_pkg::REG_ACCUMULATOR) begin
                        next_accumulator = reg_wdata_i;
                    end else if (reg_addr_i == sbd_pkg::REG_STATUS) begin
                        next_carry_flag     = reg_wdata_i[sbd_pkg::FLAG_CARRY];
                        next_aux_carry_flag =
                            reg_wdata_i[sbd_pkg::FLAG_AUX_CARRY];
                        next_zero_flag      = reg_wdata_i[sbd_pkg::FLAG_ZERO];
                        next_overflow_flag  =
                            reg_wdata_i[sbd_pkg::FLAG_OVERFLOW];
                    end
                end
            end
            sbd_pkg::SBD_DUMMY: begin
                next_done = 1'b1;                             // RULE7
            end
            default: begin
                next_state = sbd_pkg::SBD_RUN;
            end
        endcase
    end

    // Read data, valid only in the cycle after the read strobe.
    always_comb begin
        next_rdata = 8'h00;
        if (reg_rd_i) begin
            if (reg_addr_i == sbd_pkg::REG_ACCUMULATOR) begin
                next_rdata = accumulator;
            end else if (reg_addr_i == sbd_pkg::REG_STATUS) begin
                next_rdata = status_byte(carry_flag, aux_carry_flag,
                                         zero_flag, overflow_flag);
            end
        end
    end

    // Registers only; all decisions sit in the processes above.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            accumulator    <= sbd_pkg::RST_ACCUMULATOR;
            carry_flag     <= sbd_pkg::RST_FLAG;
            aux_carry_flag <= sbd_pkg::RST_FLAG;
            zero_flag      <= sbd_pkg::RST_FLAG;
            overflow_flag  <= sbd_pkg::RST_FLAG;
            mem_wdata_o    <= 8'h00;
            mem_wr_o       <= 1'b0;
            skip_o         <= 1'b0;
            busy_o         <= 1'b0;
            done_o         <= 1'b0;
            reg_rdata_o    <= 8'h00;
            state          <= sbd_pkg::SBD_RUN;
        end else begin
            accumulator    <= next_accumulator;
            carry_flag     <= next_carry_flag;
            aux_carry_flag <= next_aux_carry_flag;
            zero_flag      <= next_zero_flag;
            overflow_flag  <= next_overflow_flag;
            mem_wdata_o    <= next_mem_wdata;
            mem_wr_o       <= next_mem_wr;
            skip_o         <= next_skip;
            busy_o         <= next_busy;
            done_o         <= next_done;
            reg_rdata_o    <= next_rdata;
            state          <= next_state;
        end
    end

    // Checks that tie each result to the operands seen when it was taken.
    accum_update_a: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        take && op_i == sbd_pkg::OP_SUB_BORROW_TO_ACC |=>
        accumulator == 8'($past(accumulator) - $past(mem_data_i) -
                          {7'h00, !$past(carry_flag)}))      // RULE1
        else $error("accumulator difference wrong");

    mem_result_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        take && op_i == sbd_pkg::OP_SUB_BORROW_TO_MEM |=>
        mem_wr_o && $stable(accumulator) &&
        mem_wdata_o == 8'($past(accumulator) - $past(mem_data_i) -
                          {7'h00, !$past(carry_flag)}))      // RULE2
        else $error("memory difference wrong");

    carry_sense_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        take && op_i != sbd_pkg::OP_DECREMENT_SKIP_ZERO && op_i != 2'h3 |=>
        carry_flag == ({1'b0, $past(accumulator)} >=
                       {1'b0, $past(mem_data_i)} +
                       {8'h00, !$past(carry_flag)}))         // RULE3
        else $error("carry does not reflect borrow");

    zero_flag_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        take && op_i == sbd_pkg::OP_SUB_BORROW_TO_MEM |=>
        zero_flag == (mem_wdata_o == 8'h00) &&
        overflow_flag == (($past(accumulator[7]) != $past(mem_data_i[7])) &&
                          (mem_wdata_o[7] != $past(accumulator[7]))))  // RULE4
        else $error("zero or overflow flag wrong");

    dec_store_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        take && op_i == sbd_pkg::OP_DECREMENT_SKIP_ZERO |=>
        mem_wr_o && mem_wdata_o == 8'($past(mem_data_i) - 8'h01)
        && $stable(carry_flag))                               // RULE5
        else $error("decrement not stored");

    skip_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        take && op_i == sbd_pkg::OP_DECREMENT_SKIP_ZERO &&
        mem_data_i == 8'h01 |=> skip_o)                       // RULE6
        else $error("zero result did not skip");

    two_cycle_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        take && op_i == sbd_pkg::OP_DECREMENT_SKIP_ZERO &&
        mem_data_i == 8'h01 |=> busy_o && !done_o ##1
        done_o && !busy_o)                                    // RULE7
        else $error("skip not two cycles");

    no_skip_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        take && op_i == sbd_pkg::OP_DECREMENT_SKIP_ZERO &&
        mem_data_i != 8'h01 |=> !skip_o && !busy_o && done_o) // RULE8
        else $error("nonzero result skipped");
endmodule

// *** tb_sbd_core.sv ***
// Self-checking testbench for the subtract, borrow and decrement-skip core.
`timescale 1ns/10ps
module testbench;
    logic       sys_clk_i   = 1'b0;
    logic       rst_n_i     = 1'b0;
    logic       exec_i      = 1'b0;
    logic [1:0] op_i        = 2'h0;
    logic [7:0] mem_data_i  = 8'h00;
    logic [1:0] reg_addr_i  = 2'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic       reg_wr_i    = 1'b0;
    logic       reg_rd_i    = 1'b0;
    logic [7:0] reg_rdata_o;
    logic [7:0] mem_wdata_o;
    logic       mem_wr_o;
    logic       skip_o;
    logic       busy_o;
    logic       done_o;
    logic [7:0] model_accum;
    logic [3:0] flags;
    int         err_count   = 0;
    int         check_count = 0;
    integer     seed        = 32'h0efa_758c;

    sbd_core u_sbd_core (
        .sys_clk_i   (sys_clk_i),
        .rst_n_i     (rst_n_i),
        .exec_i      (exec_i),
        .op_i        (op_i),
        .mem_data_i  (mem_data_i),
        .reg_addr_i  (reg_addr_i),
        .reg_wdata_i (reg_wdata_i),
        .reg_wr_i    (reg_wr_i),
        .reg_rd_i    (reg_rd_i),
        .reg_rdata_o (reg_rdata_o),
        .mem_wdata_o (mem_wdata_o),
        .mem_wr_o    (mem_wr_o),
        .skip_o      (skip_o),
        .busy_o      (busy_o),
        .done_o      (done_o)
    );

    // Free-running 25 MHz clock.
    always #20 sys_clk_i = ~sys_clk_i;

    // Compares one observed byte with its expected value.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string what);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h want %h",
                     $time, what, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops the run.
    task automatic final_report;
        $display("errors %0d, checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Expected {overflow, zero, aux carry, carry, difference}.
    function automatic logic [11:0] sub_model(input logic [7:0] a,
                                              input logic [7:0] m,
                                              input logic       c);
        logic [8:0] d;
        logic [4:0] n;
        d = {1'b0, a} - {1'b0, m} - {8'h00, ~c};
        n = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, ~c};
        sub_model = {(a[7] != m[7]) && (d[7] != a[7]), d[7:0] == 8'h00,
                     ~n[4], ~d[8], d[7:0]};
    endfunction

    // One register write cycle.
    task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge sys_clk_i);
        reg_wr_i    <= 1'b0;
    endtask

    // One register read; the data stand only in the following cycle.
    task automatic reg_read(input logic [1:0] a, input logic [7:0] exp,
                            input string what);
        @(posedge sys_clk_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge sys_clk_i);
        reg_rd_i   <= 1'b0;
        #1 check(reg_rdata_o, exp, what);
    endtask

    // Issues one instruction, checks its strobes, then reads back state.
    task automatic run_op(input logic [1:0] op, input logic [7:0] m);
        logic [11:0] r;
        logic        dec;
        logic        z;
        r   = sub_model(model_accum, m, flags[0]);
        dec = (op == sbd_pkg::OP_DECREMENT_SKIP_ZERO);
        z   = dec && (m == 8'h01);
        @(posedge sys_clk_i);
        exec_i     <= 1'b1;
        op_i       <= op;
        mem_data_i <= m;
        // A request during the dummy cycle is sent on purpose; it must be lost.
        @(posedge sys_clk_i);
        exec_i     <= z;
        op_i       <= sbd_pkg::OP_SUB_BORROW_TO_MEM;
        #1;
        if (dec) begin
            check({7'h00, mem_wr_o}, 8'h01, "dec write");
            check(mem_wdata_o, m - 8'h01, "dec value");
            check({7'h00, skip_o}, {7'h00, z}, "skip");
            check({7'h00, busy_o}, {7'h00, z}, "dummy");
            check({7'h00, done_o}, {7'h00, ~z}, "dec done");
            if (z) begin
                @(posedge sys_clk_i);
                exec_i <= 1'b0;
                #1 check({4'h0, mem_wr_o, skip_o, busy_o, done_o}, 8'h01,
                         "skip end");
            end
        end else begin
            check({7'h00, done_o}, 8'h01, "sub done");
            check({6'h00, mem_wr_o, skip_o},
                  {6'h00, op == sbd_pkg::OP_SUB_BORROW_TO_MEM, 1'b0},
                  "sub write");
            if (op == sbd_pkg::OP_SUB_BORROW_TO_MEM)
                check(mem_wdata_o, r[7:0], "sub value");
            else if (op == sbd_pkg::OP_SUB_BORROW_TO_ACC)
                model_accum = r[7:0];
            // The spare code only completes; it must leave every flag alone.
            if (op != 2'h3)
                flags = r[11:8];
        end
        reg_read(sbd_pkg::REG_ACCUMULATOR, model_accum, "accum");
        reg_read(sbd_pkg::REG_STATUS, {4'h0, flags}, "flags");
    endtask

    // Main sequence: reset, corner cases, then repeatable random traffic.
    initial begin
        logic [31:0] rv;
        logic [1:0]  op;
        model_accum = 8'h00;
        flags = 4'h0;
        repeat (5) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        #1 check({4'h0, mem_wr_o, skip_o, busy_o, done_o}, 8'h00, "rst");
        reg_read(sbd_pkg::REG_ACCUMULATOR, 8'h00, "rst accum");
        reg_read(sbd_pkg::REG_STATUS, 8'h00, "rst flags");
        reg_read(2'h2, 8'h00, "unmapped");
        reg_read(2'h3, 8'h00, "unmapped");
        // Borrow in with signed overflow, then an exact zero result.
        reg_write(sbd_pkg::REG_ACCUMULATOR, 8'h80);
        model_accum = 8'h80;
        run_op(sbd_pkg::OP_SUB_BORROW_TO_ACC, 8'h01);
        run_op(sbd_pkg::OP_SUB_BORROW_TO_MEM, 8'h7e);
        run_op(sbd_pkg::OP_SUB_BORROW_TO_ACC, 8'h7e);
        run_op(sbd_pkg::OP_SUB_BORROW_TO_ACC, 8'hff);
        // The spare opcode must complete without touching any state.
        run_op(2'h3, 8'h55);
        // Decrement boundaries: to zero, wrap from zero, ordinary.
        run_op(sbd_pkg::OP_DECREMENT_SKIP_ZERO, 8'h01);
        run_op(sbd_pkg::OP_DECREMENT_SKIP_ZERO, 8'h00);
        run_op(sbd_pkg::OP_DECREMENT_SKIP_ZERO, 8'h02);
        run_op(sbd_pkg::OP_DECREMENT_SKIP_ZERO, 8'h01);
        for (int i = 0; i < 80; i++) begin
            rv = $random(seed);
            if (rv[3:0] == 4'h0) begin
                reg_write(sbd_pkg::REG_ACCUMULATOR, rv[31:24]);
                model_accum = rv[31:24];
            end
            if (rv[7:4] == 4'h0) begin
                reg_write(sbd_pkg::REG_STATUS, rv[31:24]);
                flags = rv[27:24];
            end
            op = (rv[9:8] == 2'h3 && !rv[11])
                     ? sbd_pkg::OP_DECREMENT_SKIP_ZERO : rv[9:8];
            run_op(op, (op == sbd_pkg::OP_DECREMENT_SKIP_ZERO && rv[10])
                       ? 8'h01 : rv[23:16]);
        end
        final_report;
    end

    // Watchdog at 20000 cycles, well beyond the fewer than a thousand cycles the sequence needs.
    initial begin
        #(20000 * 40);
        err_count++;
        final_report;
    end
endmodule
